//--- core/l4etc_defs.svh
// register offsets, field positions, encodings and reset values
`ifndef L4ETC_DEFS_SVH
`define L4ETC_DEFS_SVH

// ==========================================================
// register byte offsets
`define L4ETC_OFF_CTRL       6'h00
`define L4ETC_OFF_SRC_MODE   6'h04
`define L4ETC_OFF_SRC_RANGE  6'h08
`define L4ETC_OFF_DST_MODE   6'h0C
`define L4ETC_OFF_DST_RANGE  6'h10
`define L4ETC_OFF_FLAGS      6'h14
`define L4ETC_OFF_ETYPE      6'h18
`define L4ETC_OFF_PORT_DEF   6'h1C
`define L4ETC_OFF_STATUS     6'h20
`define L4ETC_OFF_HIT_COUNT  6'h24

// ==========================================================
// field positions
`define L4ETC_CTRL_EN_BIT     0
`define L4ETC_CTRL_ETYPE_BIT  1
`define L4ETC_CTRL_PERMIT_BIT 2
`define L4ETC_ETYPE_SPEC_BIT  16

// ==========================================================
// port filter modes and flag settings
`define L4ETC_MODE_ANY    2'h0
`define L4ETC_MODE_ONE    2'h1
`define L4ETC_MODE_RANGE  2'h2
`define L4ETC_FLAG_ANY    2'h0
`define L4ETC_FLAG_CLR    2'h1
`define L4ETC_FLAG_SET    2'h2

// ==========================================================
// ethertype limits
`define L4ETC_ETYPE_MIN   16'h0600
`define L4ETC_ETYPE_IPV4  16'h0800
`define L4ETC_ETYPE_ARP   16'h0806
`define L4ETC_ETYPE_IPV6  16'h86DD

// ==========================================================
// reset values and bus answers
`define L4ETC_RST_ETYPE   16'h0600
`define L4ETC_RST_HI      16'hFFFF
`define L4ETC_RESP_OKAY   2'h0
`define L4ETC_RESP_SLVERR 2'h2

`endif

//--- core/l4etc_pkg.sv
// types shared by the classifier files
package l4etc_pkg;

	// ==========================================================
	// write channel progress, gray along idle-addr-resp
	typedef enum logic [1:0] {
		L4ETC_WR_IDLE = 2'b00,
		L4ETC_WR_ADDR = 2'b01,
		L4ETC_WR_RESP = 2'b11,
		L4ETC_WR_DATA = 2'b10
	} l4etc_wr_t;

	typedef logic [1:0] l4etc_mode_t;

endpackage : l4etc_pkg

//--- core/l4etc_port_match.sv
// one port-number condition: any, single value or inclusive range
`timescale 1ns/100ps
`include "l4etc_defs.svh"

module l4etc_port_match #(
	parameter int W = 16
) (
	input  wire l4etc_pkg::l4etc_mode_t mode,
	input  wire logic [W-1:0]           lo,
	input  wire logic [W-1:0]           hi,
	input  wire logic [W-1:0]           port,
	output logic                        ok
);

	always_comb begin
		case (mode)
			`L4ETC_MODE_ONE:   ok = (port == lo);
			// both bounds count as inside
			`L4ETC_MODE_RANGE: ok = (port >= lo) && (port <= hi);
			default:           ok = 1'b1;
		endcase
	end

endmodule : l4etc_port_match

//--- core/l4etc_classifier.sv
// one access entry matcher with its axi4-lite register file
`timescale 1ns/100ps
`include "l4etc_defs.svh"

// What this block does
// [R1] source filter any ignores source port
// [R2] single source value must equal port
// [R3] source range bounds hold port
// [R4] destination filter any ignores destination port
// [R5] single destination value must equal port
// [R6] destination range bounds hold port
// [R7] FIN setting: set, clear or ignore
// [R8] SYN setting: set, clear or ignore
// [R9] RST setting: set, clear or ignore
// [R10] PSH setting: set, clear or ignore
// [R11] ACK setting: set, clear or ignore
// [R12] URG setting: set, clear or ignore
// [R13] ethertype compare only in ethertype class
// [R14] ethertype filter any or single value
// [R15] stored ethertype legal, common types refused
// [R16] port defaults apply when entry misses
// [R17] hit needs every condition at once
// [R18] range includes both bounds
module l4etc_classifier #(
	parameter int NUM_PORTS = 8,
	parameter int PORT_W    = 3,
	parameter int ADDR_W    = 6
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 frm_valid,
	input  wire logic [PORT_W-1:0]    frm_port,
	input  wire logic [15:0]          frm_src_port,
	input  wire logic [15:0]          frm_dst_port,
	input  wire logic [5:0]           frm_tcp_flags,
	input  wire logic [15:0]          frm_ethertype,
	output logic                      res_valid,
	output logic                      res_hit,
	output logic                      res_permit
);

	// ==========================================================
	// state
	typedef struct packed {
		l4etc_pkg::l4etc_wr_t   wr;
		logic [ADDR_W-1:0]      aw_addr;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic                   entry_en;
		logic                   etype_class;
		logic                   entry_permit;
		l4etc_pkg::l4etc_mode_t src_mode;
		logic [15:0]            src_lo;
		logic [15:0]            src_hi;
		l4etc_pkg::l4etc_mode_t dst_mode;
		logic [15:0]            dst_lo;
		logic [15:0]            dst_hi;
		logic [11:0]            flag_cfg;
		logic                   etype_spec;
		logic [15:0]            etype_val;
		logic [NUM_PORTS-1:0]   port_permit;
		logic                   res_valid;
		logic                   res_hit;
		logic                   res_permit;
		logic [31:0]            hit_count;
	} l4etc_state_t;

	l4etc_state_t st;
	l4etc_state_t next_st;

	// ==========================================================
	// byte-lane merge
	function automatic logic [31:0] l4etc_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : l4etc_merge

	// ==========================================================
	// legal ethertype check
	function automatic logic l4etc_etype_legal(input logic [15:0] v);
		return (v >= `L4ETC_ETYPE_MIN) && (v != `L4ETC_ETYPE_IPV4) &&
			(v != `L4ETC_ETYPE_ARP) && (v != `L4ETC_ETYPE_IPV6);
	endfunction : l4etc_etype_legal

	// ==========================================================
	// match conditions
	logic       src_ok;
	logic       dst_ok;
	logic [5:0] flag_ok;
	logic       etype_ok;
	logic       hit_now;

	// [R1] [R2] [R3] source condition
	l4etc_port_match #(
		.W (16)
	) u_src_match (
		.mode (st.src_mode),
		.lo   (st.src_lo),
		.hi   (st.src_hi),
		.port (frm_src_port),
		.ok   (src_ok)
	);

	// [R4] [R5] [R6] destination condition
	l4etc_port_match #(
		.W (16)
	) u_dst_match (
		.mode (st.dst_mode),
		.lo   (st.dst_lo),
		.hi   (st.dst_hi),
		.port (frm_dst_port),
		.ok   (dst_ok)
	);

	// flag i: 0 fin, 1 syn, 2 rst, 3 psh, 4 ack, 5 urg
	// [R7] [R8] [R9] [R10] [R11] [R12] per-flag setting
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_flag
			always_comb begin
				case (st.flag_cfg[2*gi +: 2])
					`L4ETC_FLAG_CLR: flag_ok[gi] = ~frm_tcp_flags[gi];
					`L4ETC_FLAG_SET: flag_ok[gi] = frm_tcp_flags[gi];
					default:         flag_ok[gi] = 1'b1;
				endcase
			end
		end
	endgenerate

	// [R13] [R14] ethertype only in its class
	assign etype_ok = ~st.etype_class | ~st.etype_spec |
		(frm_ethertype == st.etype_val);

	// [R17] all conditions together
	assign hit_now = st.entry_en & src_ok & dst_ok & (&flag_ok) & etype_ok;

	// ==========================================================
	// bus handshakes
	logic              aw_fire;
	logic              w_fire;
	logic              ar_fire;
	logic              got_a;
	logic              got_d;
	logic [ADDR_W-1:0] wa;
	logic [31:0]       wd;
	logic [3:0]        ws;
	logic [5:0]        wreg;
	logic [5:0]        rreg;

	assign s_axi_awready = (st.wr == l4etc_pkg::L4ETC_WR_IDLE) ||
		(st.wr == l4etc_pkg::L4ETC_WR_DATA);
	assign s_axi_wready  = (st.wr == l4etc_pkg::L4ETC_WR_IDLE) ||
		(st.wr == l4etc_pkg::L4ETC_WR_ADDR);
	assign s_axi_arready = ~st.rvalid;

	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire  = s_axi_wvalid & s_axi_wready;
	assign ar_fire = s_axi_arvalid & s_axi_arready;
	assign got_a   = aw_fire | (st.wr == l4etc_pkg::L4ETC_WR_ADDR);
	assign got_d   = w_fire | (st.wr == l4etc_pkg::L4ETC_WR_DATA);
	assign wa      = aw_fire ? s_axi_awaddr : st.aw_addr;
	assign wd      = w_fire ? s_axi_wdata : st.w_data;
	assign ws      = w_fire ? s_axi_wstrb : st.w_strb;
	// word aligned: low address bits ignored
	assign wreg    = {wa[5:2], 2'b00};
	assign rreg    = {s_axi_araddr[5:2], 2'b00};

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] old_v;
		logic [31:0] new_v;
		old_v   = 32'h0000_0000;
		new_v   = 32'h0000_0000;
		next_st = st;

		// ---- write channel
		case (st.wr)
			l4etc_pkg::L4ETC_WR_IDLE,
			l4etc_pkg::L4ETC_WR_ADDR,
			l4etc_pkg::L4ETC_WR_DATA: begin
				if (aw_fire) begin
					next_st.aw_addr = s_axi_awaddr;
				end
				if (w_fire) begin
					next_st.w_data = s_axi_wdata;
					next_st.w_strb = s_axi_wstrb;
				end
				if (got_a && got_d) begin
					next_st.wr    = l4etc_pkg::L4ETC_WR_RESP;
					next_st.bresp = `L4ETC_RESP_OKAY;
					case (wreg)
						`L4ETC_OFF_CTRL: begin
							old_v = {29'h0000_0000, st.entry_permit,
								st.etype_class, st.entry_en};
							new_v = l4etc_merge(old_v, wd, ws);
							next_st.entry_en     = new_v[`L4ETC_CTRL_EN_BIT];
							next_st.etype_class  =
								new_v[`L4ETC_CTRL_ETYPE_BIT];
							next_st.entry_permit =
								new_v[`L4ETC_CTRL_PERMIT_BIT];
						end
						`L4ETC_OFF_SRC_MODE: begin
							new_v = l4etc_merge({30'h0000_0000, st.src_mode},
								wd, ws);
							next_st.src_mode = new_v[1:0];
						end
						`L4ETC_OFF_SRC_RANGE: begin
							new_v = l4etc_merge({st.src_hi, st.src_lo},
								wd, ws);
							next_st.src_lo = new_v[15:0];
							next_st.src_hi = new_v[31:16];
						end
						`L4ETC_OFF_DST_MODE: begin
							new_v = l4etc_merge({30'h0000_0000, st.dst_mode},
								wd, ws);
							next_st.dst_mode = new_v[1:0];
						end
						`L4ETC_OFF_DST_RANGE: begin
							new_v = l4etc_merge({st.dst_hi, st.dst_lo},
								wd, ws);
							next_st.dst_lo = new_v[15:0];
							next_st.dst_hi = new_v[31:16];
						end
						`L4ETC_OFF_FLAGS: begin
							new_v = l4etc_merge({20'h0_0000, st.flag_cfg},
								wd, ws);
							next_st.flag_cfg = new_v[11:0];
						end
						`L4ETC_OFF_ETYPE: begin
							old_v = {15'h0000, st.etype_spec, st.etype_val};
							new_v = l4etc_merge(old_v, wd, ws);
							// [R15] illegal value refused, old kept
							if (l4etc_etype_legal(new_v[15:0])) begin
								next_st.etype_val  = new_v[15:0];
								next_st.etype_spec =
									new_v[`L4ETC_ETYPE_SPEC_BIT];
							end else begin
								next_st.bresp = `L4ETC_RESP_SLVERR;
							end
						end
						`L4ETC_OFF_PORT_DEF: begin
							old_v = 32'h0000_0000;
							old_v[NUM_PORTS-1:0] = st.port_permit;
							new_v = l4etc_merge(old_v, wd, ws);
							next_st.port_permit = new_v[NUM_PORTS-1:0];
						end
						`L4ETC_OFF_STATUS: begin
							next_st.bresp = `L4ETC_RESP_OKAY;
						end
						`L4ETC_OFF_HIT_COUNT: begin
							next_st.hit_count = 32'h0000_0000;
						end
						default: begin
							next_st.bresp = `L4ETC_RESP_SLVERR;
						end
					endcase
				end else if (got_a) begin
					next_st.wr = l4etc_pkg::L4ETC_WR_ADDR;
				end else if (got_d) begin
					next_st.wr = l4etc_pkg::L4ETC_WR_DATA;
				end
			end
			l4etc_pkg::L4ETC_WR_RESP: begin
				if (s_axi_bready) begin
					next_st.wr = l4etc_pkg::L4ETC_WR_IDLE;
				end
			end
			default: begin
				next_st.wr = l4etc_pkg::L4ETC_WR_IDLE;
			end
		endcase

		// ---- read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (ar_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = `L4ETC_RESP_OKAY;
			next_st.rdata  = 32'h0000_0000;
			case (rreg)
				`L4ETC_OFF_CTRL:
					next_st.rdata = {29'h0000_0000, st.entry_permit,
						st.etype_class, st.entry_en};
				`L4ETC_OFF_SRC_MODE:
					next_st.rdata = {30'h0000_0000, st.src_mode};
				`L4ETC_OFF_SRC_RANGE:
					next_st.rdata = {st.src_hi, st.src_lo};
				`L4ETC_OFF_DST_MODE:
					next_st.rdata = {30'h0000_0000, st.dst_mode};
				`L4ETC_OFF_DST_RANGE:
					next_st.rdata = {st.dst_hi, st.dst_lo};
				`L4ETC_OFF_FLAGS:
					next_st.rdata = {20'h0_0000, st.flag_cfg};
				`L4ETC_OFF_ETYPE:
					next_st.rdata = {15'h0000, st.etype_spec, st.etype_val};
				`L4ETC_OFF_PORT_DEF:
					next_st.rdata[NUM_PORTS-1:0] = st.port_permit;
				`L4ETC_OFF_STATUS:
					next_st.rdata = {29'h0000_0000, st.res_valid,
						st.res_permit, st.res_hit};
				`L4ETC_OFF_HIT_COUNT:
					next_st.rdata = st.hit_count;
				default:
					next_st.rresp = `L4ETC_RESP_SLVERR;
			endcase
		end

		// ---- classification, one cycle after the frame
		next_st.res_valid = frm_valid;
		if (frm_valid) begin
			next_st.res_hit = hit_now;
			// [R16] miss falls back to port default
			next_st.res_permit = hit_now ? st.entry_permit :
				st.port_permit[frm_port];
			// count wins over a clear in the same cycle
			if (hit_now) begin
				next_st.hit_count = st.hit_count + 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st              <= '0;
			st.wr           <= l4etc_pkg::L4ETC_WR_IDLE;
			st.src_mode     <= `L4ETC_MODE_ANY;
			st.src_hi       <= `L4ETC_RST_HI;
			st.dst_mode     <= `L4ETC_MODE_ANY;
			st.dst_hi       <= `L4ETC_RST_HI;
			st.etype_val    <= `L4ETC_RST_ETYPE;
			// ports permit by default
			st.port_permit  <= '1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_bvalid = (st.wr == l4etc_pkg::L4ETC_WR_RESP);
	assign s_axi_bresp  = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata  = st.rdata;
	assign s_axi_rresp  = st.rresp;
	assign res_valid    = st.res_valid;
	assign res_hit      = st.res_hit;
	assign res_permit   = st.res_permit;

endmodule : l4etc_classifier

//--- tb/l4etc_frame_src.sv
// frame parser stand-in: one frame per request, noise between frames
`timescale 1ns/100ps
module l4etc_frame_src (
	input  wire logic        aclk,
	input  wire logic        snd,
	input  wire logic [56:0] fld,
	output logic             frm_valid,
	output logic [2:0]       frm_port,
	output logic [15:0]      frm_src_port,
	output logic [15:0]      frm_dst_port,
	output logic [5:0]       frm_tcp_flags,
	output logic [15:0]      frm_ethertype
);
	logic [56:0] cur = 57'h0;
	logic        vld = 1'b0;

	// ==========================================================
	// launch
	assign frm_valid = vld;
	assign {frm_port, frm_src_port, frm_dst_port, frm_tcp_flags,
		frm_ethertype} = cur;
	always @(posedge aclk) begin
		vld <= snd;
		// stale fields would hide a sampling slip
		cur <= snd ? fld : ~cur;
	end
endmodule : l4etc_frame_src

//--- tb/l4etc_classifier_asserts.sv
// port assertions for the access entry classifier
`timescale 1ns/100ps
module l4etc_classifier_chk #(
	parameter int ADDR_W = 6
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              frm_valid,
	input wire logic              res_valid,
	input wire logic              res_hit,
	input wire logic              res_permit
);
	// ==========================================================
	// sequences
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence bad_etype;
		wr_taken ##0 (s_axi_awaddr[5:2] == 4'h6 && s_axi_wstrb == 4'hF
			&& s_axi_wdata[15:0] == 16'h0800);
	endsequence

	// ==========================================================
	// assertions
	a_frame_result:
	assert property (frm_valid |=> res_valid) else $error("no result");
	a_no_spurious:
	assert property (!frm_valid |=> !res_valid) else $error("extra result");
	a_result_hold:
	assert property ($past(aresetn) && !res_valid
		|-> $stable({res_hit, res_permit})) else $error("result moved");
	a_bad_etype:
	assert property (bad_etype |=> s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("ethertype not refused");
	a_write_answer:
	assert property (wr_taken |=> s_axi_bvalid) else $error("no bvalid");
	a_b_stands:
	assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_r_stands:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("r dropped");
	a_ar_block:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
	a_unmapped_rd:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 6'h28
		|=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : l4etc_classifier_chk

//--- tb/test_l4_ethertype_frame_classifier.sv
// random and corner stimulus for the access entry classifier
`timescale 1ns/100ps
module test_l4_ethertype_frame_classifier;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, snd = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, e_res;
	logic [31:0] s_axi_rdata;
	logic        frm_valid, res_valid, res_hit, res_permit;
	logic [2:0]  frm_port;
	logic [15:0] frm_src_port, frm_dst_port, frm_ethertype;
	logic [5:0]  frm_tcp_flags;
	logic [56:0] fld = 57'h0;
	logic [31:0] cfg [8];
	logic [1:0]  q [$];
	int          failures = 0, n_tests = 0, exp_hits = 0;

	l4etc_classifier uut (.*);
	l4etc_frame_src u_src (.aclk(aclk), .snd(snd), .fld(fld),
		.frm_valid(frm_valid), .frm_port(frm_port),
		.frm_src_port(frm_src_port), .frm_dst_port(frm_dst_port),
		.frm_tcp_flags(frm_tcp_flags), .frm_ethertype(frm_ethertype));

	initial begin
		forever #25 aclk = ~aclk;
	end

	// ==========================================================
	// reporting
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic tmo;
		$display("wrong value at %0t: bus wait ran out", $time);
		failures++;
		end_of_test();
	endtask : tmo

	// ==========================================================
	// register bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom);
		for (int n = 0; n < 40 && !tb; n++) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid === 1'b1 && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			s_axi_bready <= !tb;
		end
		if (!tb)
			tmo();
	endtask : wr
	task automatic rd_reg(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		tr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom);
		for (int n = 0; n < 40 && !tr; n++) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid === 1'b1 && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			s_axi_rready <= !tr;
		end
		if (!tr)
			tmo();
	endtask : rd_reg

	// ==========================================================
	// expectations
	function automatic logic [31:0] ord(logic [31:0] x);
		return x[31:16] < x[15:0] ? {x[15:0], x[31:16]} : x;
	endfunction : ord
	function automatic logic [15:0] pick(logic [31:0] x);
		case ($urandom % 6)
			0: return x[15:0];
			1: return x[31:16];
			2: return x[15:0] - 16'h1;
			3: return x[31:16] + 16'h1;
			default: return 16'($urandom);
		endcase
	endfunction : pick
	function automatic logic pok(logic [31:0] m, x, logic [15:0] p);
		if (m == 32'h1)
			return p == x[15:0];
		if (m == 32'h2)
			return p >= x[15:0] && p <= x[31:16];
		return 1'b1;
	endfunction : pok
	function automatic logic [1:0] model(logic [56:0] f);
		logic h;
		h = cfg[0][0] && pok(cfg[1], cfg[2], f[53:38])
			&& pok(cfg[3], cfg[4], f[37:22]);
		for (int i = 0; i < 6; i++)
			if (cfg[5][2 * i +: 2] inside {2'h1, 2'h2})
				h = h && f[16 + i] == cfg[5][2 * i + 1];
		if (cfg[0][1] && cfg[6][16] && f[15:0] != cfg[6][15:0])
			h = 1'b0;
		return {h, h ? cfg[0][2] : cfg[7][f[56:54]]};
	endfunction : model

	always @(negedge aclk) begin
		if (res_valid === 1'b1) begin
			e_res = q.size() ? q.pop_front() : 2'bxx;
			exp_hits += e_res[1];
			chk({res_hit, res_permit}, e_res);
		end
	end

	// ==========================================================
	// main sequence
	localparam logic [31:0] RST [11] = '{0, 0, 32'hFFFF0000, 0,
		32'hFFFF0000, 0, 32'h600, 32'hFF, 0, 0, 0};
	localparam logic [15:0] BAD [4] = '{16'h5FF, 16'h800, 16'h806, 16'h86DD};

	initial begin
		logic [31:0] v;
		logic [1:0]  r;
		logic [5:0]  ff;
		logic [56:0] f;
		logic        s;
		v = $urandom(32'h24010576);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// last slot is unmapped
		for (int i = 0; i < 11; i++) begin
			rd_reg(6'(4 * i), v, r);
			chk(v, RST[i]);
			chk(r, i == 10 ? 2'h2 : 2'h0);
		end
		wr(6'h2C, 32'h1, r);
		chk(r, 2'h2);
		foreach (BAD[i]) begin
			wr(6'h18, {16'h1, BAD[i]}, r);
			chk(r, 2'h2);
			rd_reg(6'h18, v, r);
			chk(v, 32'h600);
		end
		$display("test defaults and refusals done");
		for (int k = 0; k < 150; k++) begin
			for (int j = 0; j < 8; j++)
				cfg[j] = $urandom;
			cfg[0] = cfg[0] & 32'h7 | 32'(k % 4 != 0);
			cfg[1] = cfg[1] & 32'h3;
			cfg[2] = ord(cfg[2]);
			cfg[3] = cfg[3] & 32'h3;
			cfg[4] = ord(cfg[4]);
			cfg[5] = cfg[5] & 32'hFFF;
			cfg[6] = cfg[6] & 32'h1FFFF | 32'h600;
			if (cfg[6][15:0] inside {16'h800, 16'h806, 16'h86DD})
				cfg[6][15:0] = 16'h600;
			cfg[7] = cfg[7] & 32'hFF;
			for (int j = 0; j < 8; j++) begin
				wr(6'(4 * j), cfg[j], r);
				chk(r, 2'h0);
				rd_reg(6'(4 * j), v, r);
				chk(v, cfg[j]);
			end
			wr(6'h24, 32'h0, r);
			exp_hits = 0;
			for (int m = 0; m < 12; m++) begin
				@(posedge aclk);
				ff = 6'($urandom);
				if ($urandom % 4 != 0)
					for (int i = 0; i < 6; i++)
						if (cfg[5][2 * i +: 2] inside {2'h1, 2'h2})
							ff[i] = cfg[5][2 * i + 1];
				f = {3'($urandom), pick(cfg[2]), pick(cfg[4]), ff,
					$urandom % 2 ? cfg[6][15:0] : 16'($urandom)};
				s = $urandom % 3 != 0;
				snd <= s;
				fld <= f;
				if (s)
					q.push_back(model(f));
			end
			@(posedge aclk);
			snd <= 1'b0;
			repeat (4) @(posedge aclk);
			chk(q.size(), 0);
			rd_reg(6'h24, v, r);
			chk(v, exp_hits);
		end
		$display("test random frames done");
		end_of_test();
	end
endmodule : test_l4_ethertype_frame_classifier

bind l4etc_classifier l4etc_classifier_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
